// file: tb/adcdp_capture.sv
// Capture latch model: half-rate merge, drives sync
`timescale 1ns/1ps
module adcdp_capture(input wire core_clk, input wire syncReq,
	input wire [7:0] portA, input wire [7:0] portB,
	output reg phaseAlignInput = 0, output reg [15:0] word = 0);
	reg half_r = 0;
	always @(posedge core_clk) begin
		half_r <= ~half_r;
		phaseAlignInput <= syncReq & half_r;
		if (half_r) word <= {portA, portB};
	end
endmodule

// file: tb/adcdp_monitor.sv
// Port assertions for the output stage
`timescale 1ns/1ps
module adcdp_monitor(input wire core_clk, input wire resetn,
	input wire [7:0] sampleIn, input wire outputSplitSelectN,
	input wire phaseAlignInput, input wire [7:0] portA,
	input wire [7:0] portB);
	reg [3:0] quiet_r;
	wire sel = outputSplitSelectN;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Cycles since the sync pin was last high, saturating at 15
	always @(posedge core_clk or negedge resetn)
		if (!resetn) quiet_r <= 0;
		else quiet_r <= phaseAlignInput ? 0 : quiet_r + (quiet_r != 15);
	a_single_lat: assert property (sel && $past(sel, 8)
		|-> portA == $past(sampleIn, 5)) else $error("single latency");
	a_portb_static: assert property (sel && $past(sel, 3)
		|-> $stable(portB)) else $error("port B moved");
	a_dual_lat: assert property (quiet_r == 15 && !sel && $past(!sel, 9)
		|-> portA == $past(sampleIn, 6) || portB == $past(sampleIn, 6))
		else $error("dual latency");
	a_dual_alt: assert property (quiet_r == 15 && !sel && $past(!sel, 9)
		&& $changed(portA) |-> $stable(portB) ##1 $stable(portA))
		else $error("ports not alternating");
	a_portb_hold: assert property (quiet_r == 15 && !sel && $past(!sel, 9)
		&& $changed(portB) |=> $stable(portB)) else $error("port B short");
	a_sync_phase: assert property (!sel && $past(!sel, 9)
		&& $fell(phaseAlignInput) |-> ##5 portB == $past(sampleIn, 6))
		else $error("sync phase wrong");
endmodule

// file: tb/adcdp_output_sync_test.sv
// Bench for the output stage
`timescale 1ns/1ps
module adcdp_output_sync_test;
	reg core_clk = 0, resetn = 0, sel = 1, syncReq = 0;
	reg [7:0] sampleIn = 0, v;
	wire [7:0] portA, portB;
	wire phaseAlignInput;
	int miscompares = 0, n_checks = 0, cyc = 0, lat = 5, k;
	reg b;
	logic [8:0] e;
	logic [8:0] expQ[$];
	adcdp_output_sync dut(.core_clk(core_clk), .resetn(resetn),
		.sampleIn(sampleIn), .outputSplitSelectN(sel),
		.phaseAlignInput(phaseAlignInput), .portA(portA), .portB(portB));
	adcdp_capture model(.core_clk(core_clk), .syncReq(syncReq),
		.portA(portA), .portB(portB),
		.phaseAlignInput(phaseAlignInput), .word());
	initial forever #25 core_clk = ~core_clk;
	task end_of_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			miscompares++;
			end_of_test;
		end
	end
	always @(negedge core_clk) if (expQ.size() > lat) begin
		e = expQ.pop_front();
		n_checks++;
		if ((e[8] ? portB : portA) !== e[7:0]) begin
			miscompares++;
			$display("unexpected %0t port value", $time);
		end
	end
	initial begin
		void'($urandom(32'h1ae1));
		repeat (20) @(posedge core_clk);
		resetn <= 1;
		repeat (40) @(posedge core_clk) begin
			v = 8'($urandom);
			sampleIn <= v;
			expQ.push_back({1'b0, v});
		end
		@(posedge core_clk) expQ.delete();
		$display("single port test done");
		sel <= 0;
		syncReq <= 1;
		lat = 6;
		repeat (2) @(posedge core_clk);
		// Pin has just fallen; captures from the next edge go A, B
		b = 0;
		for (k = 0; k < 80; k++) begin
			if (k == 40) syncReq <= 0;
			v = 8'($urandom);
			sampleIn <= v;
			expQ.push_back({b, v});
			b = ~b;
			@(posedge core_clk);
		end
		repeat (8) @(posedge core_clk);
		$display("dual port test done");
		end_of_test;
	end
endmodule
bind adcdp_output_sync adcdp_monitor mon(.core_clk(core_clk),
	.resetn(resetn), .sampleIn(sampleIn),
	.outputSplitSelectN(outputSplitSelectN),
	.phaseAlignInput(phaseAlignInput), .portA(portA), .portB(portB));

// file: verilog/adcdp_consts.vh
// Constants for the dual port converter output stage
`ifndef ADCDP_CONSTS_VH
`define ADCDP_CONSTS_VH
`define ADCDP_DATA_W 8
`define ADCDP_LAT_SINGLE 4
`define ADCDP_LAT_DUAL 5
`define ADCDP_PHASE_RST 1'b0
`define ADCDP_PORTB_RST 8'h00
`endif

// file: verilog/adcdp_output_sync.v
// Output steering, pipeline and phase alignment of the converter
// Contract
// - Dual mode alternates results between ports A, B
// - Alternation divider starts at arbitrary phase
// - Conflicting sync corrupts one sample, then fixed
// - Matching sync leaves output data unchanged
// - Dual mode latency is six clock cycles
// - Single mode: every cycle on port A
// - Single mode latency is five clock cycles
// - Single mode holds port B static
`timescale 1ns/1ps
`include "adcdp_consts.vh"
module adcdp_output_sync #(
	parameter DATA_W = `ADCDP_DATA_W
) (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// Sample stream, one per clock, same domain
	input wire [DATA_W-1:0] sampleIn,
	// Pins from the controlling party
	input wire outputSplitSelectN,
	input wire phaseAlignInput,
	// Output ports
	output reg [DATA_W-1:0] portA,
	output reg [DATA_W-1:0] portB
);
	// Samples enter every edge and leave at a fixed tap. In dual
	// mode a two-slot divider picks the port; a falling edge on
	// the sync pin forces the slot, so a pulse train in step with
	// the divider changes nothing.
	// Pipeline depth covers the longer dual mode latency
	localparam DEPTH = `ADCDP_LAT_DUAL;
	// Output taps; the port register adds the last delay
	localparam TAP_SINGLE = `ADCDP_LAT_SINGLE - 1;
	localparam TAP_DUAL = `ADCDP_LAT_DUAL - 1;
	// Divider slots, one-hot; slot B steers the write one cycle later to B
	localparam SLOT_A = 2'b01;
	localparam SLOT_B = 2'b10;
	localparam SLOT_RST = (`ADCDP_PHASE_RST == 1'b1) ? SLOT_B : SLOT_A;

	// Mode pin synchroniser
	reg splitMeta_r;
	reg splitSync_r;
	// Sync pin synchroniser and edge history
	reg alignMeta_r;
	reg alignSync_r;
	reg alignPrev_r;
	// Sample pipeline
	reg [DATA_W-1:0] pipe_r [0:DEPTH-1];
	// Divider and steering
	reg [1:0] slot_r;
	reg [1:0] slot_nxt;
	reg steerB_r;
	reg steerB_nxt;
	// Port next values
	reg [DATA_W-1:0] portA_nxt;
	reg [DATA_W-1:0] portB_nxt;
	// Decoded controls
	wire dualMode;
	wire syncFall;
	integer i;

	// Reset reads as single mode, the rate-safe choice
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			splitMeta_r <= 1'b1;
		end else begin
			splitMeta_r <= outputSplitSelectN;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			splitSync_r <= 1'b1;
		end else begin
			splitSync_r <= splitMeta_r;
		end
	end

	// Low on the pin selects dual mode
	assign dualMode = ~splitSync_r;

	// Sync pin resets low so reset alone makes no edge
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alignMeta_r <= 1'b0;
		end else begin
			alignMeta_r <= phaseAlignInput;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alignSync_r <= 1'b0;
		end else begin
			alignSync_r <= alignMeta_r;
		end
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alignPrev_r <= 1'b0;
		end else begin
			alignPrev_r <= alignSync_r;
		end
	end

	// Only the falling edge acts; its rising edge carries no timing
	assign syncFall = alignPrev_r & ~alignSync_r;

	// Samples come from logic on core_clk, so no synchroniser
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				pipe_r[i] <= {DATA_W{1'b0}};
			end
		end else begin
			pipe_r[0] <= sampleIn;
			for (i = 1; i < DEPTH; i = i + 1) begin
				pipe_r[i] <= pipe_r[i-1];
			end
		end
	end

	// The divider runs free from an arbitrary phase; nothing ties
	// it to the data until the first sync
	always @* begin
		slot_nxt = SLOT_A;
		case (slot_r)
			SLOT_A: begin
				slot_nxt = SLOT_B;
			end
			SLOT_B: begin
				slot_nxt = SLOT_A;
			end
			default: begin
				slot_nxt = SLOT_A;
			end
		endcase
		if (syncFall) begin
			slot_nxt = SLOT_B;
		end
	end

	// Reset phase is a free choice; only a sync defines it
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slot_r <= SLOT_RST;
		end else begin
			slot_r <= slot_nxt;
		end
	end

	// A sync in step forces the slot the divider reaches anyway.
	// Out of step it repeats slot B, so one sample on port B is
	// overwritten before the order settles.
	always @* begin
		steerB_nxt = 1'b0;
		case (slot_r)
			SLOT_B: begin
				steerB_nxt = 1'b1;
			end
			default: begin
				steerB_nxt = 1'b0;
			end
		endcase
	end

	// Steering lags the slot by one cycle to line up with the tap
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			steerB_r <= 1'b0;
		end else begin
			steerB_r <= steerB_nxt;
		end
	end

	// Dual mode writes one port per cycle, so each holds two
	always @* begin
		portA_nxt = portA;
		portB_nxt = portB;
		if (dualMode) begin
			if (steerB_r) begin
				portB_nxt = pipe_r[TAP_DUAL];
			end else begin
				portA_nxt = pipe_r[TAP_DUAL];
			end
		end else begin
			// Port B is never written, so it keeps a stale value
			portA_nxt = pipe_r[TAP_SINGLE];
		end
	end

	// Outputs straight from flops
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			portA <= {DATA_W{1'b0}};
		end else begin
			portA <= portA_nxt;
		end
	end

	// Port B reset value is arbitrary, as its single mode content
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			portB <= `ADCDP_PORTB_RST;
		end else begin
			portB <= portB_nxt;
		end
	end
endmodule
